// ### design/pin_serial_regs.sv
// How it works
// - The spare top word bit is never decoded; after a full frame it only shows on the serial output.
// - Calibration-select set writes the trim register (nothing at code 8), clear writes level or control.
// - Channel 1 is written only when its enable bit is set.
// - Channel 0 is written only when its enable bit is set; both may be.
// - Word holds a 4-bit register address then 16 data bits.
// - Code 0 is driver control, code 8 unit control, others are converter levels.
// - Code 13: channel 0 is voltage offset, channel 1 is current offset.
// - Data bits enter most significant first.
// - Driver control decodes slew, leak, termination, load, invert, differential, cal, high drive.
// - Power-up values 0x0004, 0x0008 and 0x0003 for the three control registers.
// - Trim holds offset in 7:0, gain above: 14:8 for force value, 9:8 at code 0, else 13:8.
// - Each level code is a full 16-bit unsigned value.
// - Twenty-eight independent level codes across both channels.
// - Shared codes drive comparator and unit limit, unit clamp and high-drive level.
// - One voltage-offset code feeds both channels at once.
// - One current-offset code feeds both channels at once.
// - Bits shift in on serial clock rising edges while select is low.
// - Strobe high at select rise stages the word; strobe fall applies it.
// - Trim registers update at select rise whatever the strobe does.
`timescale 1ns/1ps
module pin_serial_regs
  import pin_pkg::*;
(
  input  wire logic                         CLK_SYS_IN,
  input  wire logic                         NRST_IN,
  input  wire logic                         SEL_N_IN,
  input  wire logic                         SCLK_IN,
  input  wire logic                         SDI_IN,
  input  wire logic                         UPDATE_N_IN,
  output logic                              SDO_OUT,
  output logic [1:0][1:0]                   SLEW_CONTROL_OUT,
  output logic [1:0]                        LOW_LEAK_SELECT_OUT,
  output logic [1:0]                        TERMINATION_SELECT_OUT,
  output logic [1:0]                        ACTIVE_LOAD_DISABLE_OUT,
  output logic [1:0]                        DATA_INVERT_OUT,
  output logic [1:0]                        DIFFERENTIAL_SELECT_OUT,
  output logic [1:0]                        LOAD_CALIBRATION_ENABLE_OUT,
  output logic [1:0]                        HIGH_VOLTAGE_DRIVE_ENABLE_OUT,
  output logic [1:0][3:0]                   OUTPUT_RESISTANCE_SELECT_OUT,
  output logic [1:0][2:0]                   COMPARATOR_HYSTERESIS_SELECT_OUT,
  output logic [1:0][2:0]                   CABLE_DROOP_COMP_OUT,
  output logic [1:0]                        FORCE_MODE_SELECT_OUT,
  output logic [1:0]                        MEASURE_MODE_SELECT_OUT,
  output logic [1:0][2:0]                   CURRENT_RANGE_SELECT_OUT,
  output logic [1:0]                        CLAMP_ENABLE_OUT,
  output logic [1:0]                        FORCE_OUTPUT_FLOAT_OUT,
  output logic [1:0]                        MEASURE_OUTPUT_FLOAT_OUT,
  output logic [1:0]                        UNIT_COMPARATOR_DISABLE_OUT,
  output logic [1:0]                        MEASURE_INPUT_SELECT_OUT,
  output logic [1:0]                        UNIT_COMPARATOR_HYSTERESIS_ON_OUT,
  output logic [1:0]                        FORCE_SWITCH_ENABLE_OUT,
  output logic [1:0]                        SENSE_SWITCH_ENABLE_OUT,
  output logic [1:0][REG_NUM-1:0][15:0]     LEVEL_CODE_OUT,
  output logic [1:0][15:0]                  COMPARE_HIGH_LEVEL_OUT,
  output logic [1:0][15:0]                  UNIT_UPPER_LIMIT_OUT,
  output logic [1:0][15:0]                  COMPARE_LOW_LEVEL_OUT,
  output logic [1:0][15:0]                  UNIT_LOWER_LIMIT_OUT,
  output logic [1:0][15:0]                  UNIT_CLAMP_HIGH_OUT,
  output logic [1:0][15:0]                  SUPER_VOLTAGE_LEVEL_OUT,
  output logic [1:0][15:0]                  VOLTAGE_OFFSET_LEVEL_OUT,
  output logic [1:0][15:0]                  CURRENT_OFFSET_LEVEL_OUT,
  output logic [1:0][REG_NUM-1:0][7:0]      OFFSET_TRIM_OUT,
  output logic [1:0][REG_NUM-1:0][6:0]      GAIN_TRIM_OUT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                            sel_q;
    logic                            sclk_q;
    logic                            upd_q;
    logic                            pending;
    logic [WORD_BITS-1:0]            staged;
    logic [1:0][15:0]                dcl_ctrl;
    logic [1:0][15:0]                mu_ctrl;
    logic [1:0][REG_NUM-1:0][15:0]   level;
    logic [1:0][REG_NUM-1:0][15:0]   trim;
    logic                            sdo;
  } state_t;

  state_t               s_r;
  state_t               s_nxt;
  state_t               s_rst;
  logic [3:0]           pins_f;
  logic                 sel_f;
  logic                 sclk_f;
  logic                 sdi_f;
  logic                 upd_f;
  logic                 sel_rise;
  logic                 sclk_rise;
  logic                 upd_fall;
  logic                 shift_en;
  logic [WORD_BITS-1:0] word;
  logic [3:0]           waddr;
  logic [15:0]          wdata;

  // ----------------------------------------------------------------
  // Pin sampling and serial capture
  // ----------------------------------------------------------------
  pin_input_sync #(.W(4)) u_sync (
    .clk_in    (CLK_SYS_IN),
    .nrst_in   (NRST_IN),
    .pin_in    ({UPDATE_N_IN, SDI_IN, SCLK_IN, SEL_N_IN}),
    .level_out (pins_f)
  );

  assign sel_f     = pins_f[0];
  assign sclk_f    = pins_f[1];
  assign sdi_f     = pins_f[2];
  assign upd_f     = pins_f[3];
  assign sel_rise  = sel_f & ~s_r.sel_q;
  assign sclk_rise = sclk_f & ~s_r.sclk_q;
  assign upd_fall  = ~upd_f & s_r.upd_q;
  assign shift_en  = sclk_rise & ~sel_f;

  // Shifting left puts the earliest bit on top: spare bit first, data MSB first
  pin_shift_in u_shift (
    .clk_in      (CLK_SYS_IN),
    .nrst_in     (NRST_IN),
    .shift_en_in (shift_en),
    .bit_in      (sdi_f),
    .word_out    (word)
  );

  assign waddr = word[ADDR_LSB +: ADDR_BITS];
  assign wdata = word[DATA_BITS-1:0];

  // ----------------------------------------------------------------
  // Working register write
  // ----------------------------------------------------------------
  // The spare bit is never looked at, so either value behaves the same
  function automatic state_t apply_word(input state_t s, input logic [WORD_BITS-1:0] w);
    state_t     r;
    logic [3:0] a;
    r = s;
    a = w[ADDR_LSB +: ADDR_BITS];
    for (int ch = 0; ch < CH_NUM; ch++) begin
      if (w[CH0_EN_BIT + ch]) begin
        if (a == ADDR_DCL_CTRL) begin
          r.dcl_ctrl[ch] = w[DATA_BITS-1:0];
        end else if (a == ADDR_MU_CTRL) begin
          r.mu_ctrl[ch] = w[DATA_BITS-1:0];
        end else begin
          r.level[ch][a] = w[DATA_BITS-1:0];
        end
      end
    end
    return r;
  endfunction : apply_word

  always_comb begin
    s_rst = '0;
    s_rst.sel_q  = 1'b1;
    s_rst.sclk_q = 1'b1;
    s_rst.upd_q  = 1'b1;
    for (int ch = 0; ch < CH_NUM; ch++) begin
      s_rst.dcl_ctrl[ch] = DCL_CTRL_RST;
      s_rst.mu_ctrl[ch]  = MU_CTRL_RST;
      for (int a = 0; a < REG_NUM; a++) begin
        s_rst.level[ch][a] = LEVEL_RST;
        s_rst.trim[ch][a]  = trim_reset(4'(a));
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // A staged word goes out before a new one in the same cycle, so the newer wins
  always_comb begin
    s_nxt        = s_r;
    s_nxt.sel_q  = sel_f;
    s_nxt.sclk_q = sclk_f;
    s_nxt.upd_q  = upd_f;
    s_nxt.sdo    = word[WORD_BITS-1];
    if (upd_fall && s_r.pending) begin
      s_nxt         = apply_word(s_nxt, s_r.staged);
      s_nxt.pending = 1'b0;
    end
    if (sel_rise) begin
      if (word[CAL_SEL_BIT]) begin
        if (waddr != ADDR_MU_CTRL) begin
          for (int ch = 0; ch < CH_NUM; ch++) begin
            if (word[CH0_EN_BIT + ch]) begin
              s_nxt.trim[ch][waddr] = wdata & trim_mask(waddr);
            end
          end
        end
      end else if (upd_f) begin
        s_nxt.staged  = word;
        s_nxt.pending = 1'b1;
      end else begin
        s_nxt         = apply_word(s_nxt, word);
        s_nxt.pending = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      s_r <= s_rst;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign SDO_OUT        = s_r.sdo;
  assign LEVEL_CODE_OUT = s_r.level;

  genvar c;
  generate
    for (c = 0; c < CH_NUM; c++) begin : g_ch
      assign SLEW_CONTROL_OUT[c]                 = s_r.dcl_ctrl[c][SLEW_LSB +: 2];
      assign LOW_LEAK_SELECT_OUT[c]              = s_r.dcl_ctrl[c][LOW_LEAK_BIT];
      assign TERMINATION_SELECT_OUT[c]           = s_r.dcl_ctrl[c][TERM_BIT];
      assign ACTIVE_LOAD_DISABLE_OUT[c]          = s_r.dcl_ctrl[c][LOAD_DIS_BIT];
      assign DATA_INVERT_OUT[c]                  = s_r.dcl_ctrl[c][INVERT_BIT];
      assign DIFFERENTIAL_SELECT_OUT[c]          = s_r.dcl_ctrl[c][DIFF_BIT];
      assign LOAD_CALIBRATION_ENABLE_OUT[c]      = s_r.dcl_ctrl[c][LOAD_CAL_BIT];
      assign HIGH_VOLTAGE_DRIVE_ENABLE_OUT[c]    = s_r.dcl_ctrl[c][HV_EN_BIT];
      assign OUTPUT_RESISTANCE_SELECT_OUT[c]     = s_r.trim[c][ADDR_DCL_CTRL][RES_LSB +: 4];
      assign COMPARATOR_HYSTERESIS_SELECT_OUT[c] = s_r.trim[c][ADDR_DCL_CTRL][COMPARATOR_HYSTERESIS_SELECT_LSB +: 3];
      assign CABLE_DROOP_COMP_OUT[c]             = s_r.trim[c][ADDR_DCL_CTRL][DROOP_LSB +: 3];
      assign FORCE_MODE_SELECT_OUT[c]            = s_r.mu_ctrl[c][FORCE_MODE_SELECT_BIT];
      assign MEASURE_MODE_SELECT_OUT[c]          = s_r.mu_ctrl[c][MEASURE_MODE_SELECT_BIT];
      assign CURRENT_RANGE_SELECT_OUT[c]         = s_r.mu_ctrl[c][RANGE_LSB +: 3];
      assign CLAMP_ENABLE_OUT[c]                 = s_r.mu_ctrl[c][CLAMP_BIT];
      assign FORCE_OUTPUT_FLOAT_OUT[c]           = s_r.mu_ctrl[c][FFLOAT_BIT];
      assign MEASURE_OUTPUT_FLOAT_OUT[c]         = s_r.mu_ctrl[c][MFLOAT_BIT];
      assign UNIT_COMPARATOR_DISABLE_OUT[c]      = s_r.mu_ctrl[c][CMP_DIS_BIT];
      assign MEASURE_INPUT_SELECT_OUT[c]         = s_r.mu_ctrl[c][MSENSE_BIT];
      assign UNIT_COMPARATOR_HYSTERESIS_ON_OUT[c] = s_r.mu_ctrl[c][UHYST_BIT];
      assign FORCE_SWITCH_ENABLE_OUT[c]          = s_r.mu_ctrl[c][FSW_BIT];
      assign SENSE_SWITCH_ENABLE_OUT[c]          = s_r.mu_ctrl[c][SSW_BIT];
      // One code each, fanned to both functions so they can never disagree
      assign COMPARE_HIGH_LEVEL_OUT[c]   = s_r.level[c][ADDR_CMP_HIGH];
      assign UNIT_UPPER_LIMIT_OUT[c]     = s_r.level[c][ADDR_CMP_HIGH];
      assign COMPARE_LOW_LEVEL_OUT[c]    = s_r.level[c][ADDR_CMP_LOW];
      assign UNIT_LOWER_LIMIT_OUT[c]     = s_r.level[c][ADDR_CMP_LOW];
      assign UNIT_CLAMP_HIGH_OUT[c]      = s_r.level[c][ADDR_CLAMP_HIGH];
      assign SUPER_VOLTAGE_LEVEL_OUT[c]  = s_r.level[c][ADDR_CLAMP_HIGH];
      assign VOLTAGE_OFFSET_LEVEL_OUT[c] = s_r.level[0][ADDR_OFFSET];
      assign CURRENT_OFFSET_LEVEL_OUT[c] = s_r.level[1][ADDR_OFFSET];
      for (genvar a = 0; a < REG_NUM; a++) begin : g_trim
        assign OFFSET_TRIM_OUT[c][a] = s_r.trim[c][a][OFFS_LSB +: 8];
        assign GAIN_TRIM_OUT[c][a]   = s_r.trim[c][a][GAIN_LSB +: 7];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!NRST_IN);

  reset_values_a: assert property ($rose(NRST_IN) |-> s_r.dcl_ctrl[0] == DCL_CTRL_RST &&
      s_r.trim[1][ADDR_DCL_CTRL] == DCL_TRIM_RST && s_r.mu_ctrl[1] == MU_CTRL_RST)
    else $error("control registers not at power-up values");
  msb_first_a: assert property (shift_en |=> word[0] == $past(sdi_f))
    else $error("serial bit not shifted in at bottom");
  hold_shift_a: assert property (sel_f |=> $stable(word))
    else $error("shift register moved while deselected");
  trim_write_a: assert property (sel_rise && word[CAL_SEL_BIT] && word[CH0_EN_BIT]
      && waddr != ADDR_MU_CTRL |=> s_r.trim[0][$past(waddr)] == ($past(wdata) & trim_mask($past(waddr))))
    else $error("trim register not written at select rise");
  ch1_guard_a: assert property (!(sel_rise && word[CAL_SEL_BIT] && word[CH1_EN_BIT])
      |=> $stable(s_r.trim[1]))
    else $error("channel 1 trim changed without its enable");
  ch0_guard_a: assert property (sel_rise && !upd_f && !word[CAL_SEL_BIT] && !word[CH0_EN_BIT]
      && !(upd_fall && s_r.pending) |=> $stable(s_r.level[0]) && $stable(s_r.dcl_ctrl[0]))
    else $error("channel 0 changed without its enable");
  staged_hold_a: assert property (sel_rise && upd_f && !word[CAL_SEL_BIT]
      |=> s_r.pending && $stable(s_r.level) && $stable(s_r.mu_ctrl))
    else $error("staged word reached working registers early");
  staged_apply_a: assert property (upd_fall && s_r.pending && s_r.staged[CH1_EN_BIT] &&
      !sel_rise && s_r.staged[ADDR_LSB +: ADDR_BITS] == ADDR_MU_CTRL
      |=> s_r.mu_ctrl[1] == $past(s_r.staged[DATA_BITS-1:0]) && !s_r.pending)
    else $error("staged word not applied on strobe fall");
  gain_width_a: assert property (s_r.trim[0][ADDR_CLAMP_HIGH][15:14] == 2'h0 &&
      s_r.trim[1][ADDR_FORCE][15] == 1'b0)
    else $error("trim gain wider than its field");
  offset_shared_a: assert property (VOLTAGE_OFFSET_LEVEL_OUT[0] == VOLTAGE_OFFSET_LEVEL_OUT[1])
    else $error("voltage offset differs between channels");

  direct_write_c: cover property (sel_rise && !upd_f && !word[CAL_SEL_BIT]);
  staged_write_c: cover property (sel_rise && upd_f ##[1:400] upd_fall && s_r.pending);
  trim_write_c: cover property (sel_rise && word[CAL_SEL_BIT] && &word[CH1_EN_BIT:CH0_EN_BIT]);

endmodule : pin_serial_regs

// ### design/pin_pkg.sv
package pin_pkg;

  // ----------------------------------------------------------------
  // Command word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS   = 24;
  localparam int DATA_BITS   = 16;
  localparam int ADDR_BITS   = 4;
  localparam int CH_NUM      = 2;
  localparam int REG_NUM     = 16;
  localparam int SPARE_BIT   = 23;
  localparam int CAL_SEL_BIT = 22;
  localparam int CH1_EN_BIT  = 21;
  localparam int CH0_EN_BIT  = 20;
  localparam int ADDR_LSB    = 16;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_DCL_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_CMP_HIGH   = 4'h4;
  localparam logic [3:0] ADDR_CMP_LOW    = 4'h5;
  localparam logic [3:0] ADDR_MU_CTRL    = 4'h8;
  localparam logic [3:0] ADDR_FORCE      = 4'h9;
  localparam logic [3:0] ADDR_OFFSET     = 4'hd;
  localparam logic [3:0] ADDR_CLAMP_HIGH = 4'he;

  // ----------------------------------------------------------------
  // Reset values and trim masks
  // ----------------------------------------------------------------
  localparam logic [15:0] DCL_CTRL_RST    = 16'h0004;
  localparam logic [15:0] DCL_TRIM_RST    = 16'h0008;
  localparam logic [15:0] MU_CTRL_RST     = 16'h0003;
  localparam logic [15:0] LEVEL_RST       = 16'h4000;
  localparam logic [15:0] TRIM_RST        = 16'h2080;
  localparam logic [15:0] FORCE_TRIM_RST  = 16'h4080;
  localparam logic [15:0] TRIM_MASK       = 16'h3fff;
  localparam logic [15:0] FORCE_TRIM_MASK = 16'h7fff;
  localparam logic [15:0] DCL_TRIM_MASK   = 16'h03ff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SLEW_LSB      = 0;
  localparam int LOW_LEAK_BIT  = 2;
  localparam int TERM_BIT      = 3;
  localparam int LOAD_DIS_BIT  = 4;
  localparam int INVERT_BIT    = 5;
  localparam int DIFF_BIT      = 6;
  localparam int LOAD_CAL_BIT  = 7;
  localparam int HV_EN_BIT     = 8;
  localparam int RES_LSB       = 0;
  localparam int COMPARATOR_HYSTERESIS_SELECT_LSB      = 4;
  localparam int DROOP_LSB     = 7;
  localparam int FORCE_MODE_SELECT_BIT     = 0;
  localparam int MEASURE_MODE_SELECT_BIT     = 1;
  localparam int RANGE_LSB     = 2;
  localparam int CLAMP_BIT     = 5;
  localparam int FFLOAT_BIT    = 6;
  localparam int MFLOAT_BIT    = 7;
  localparam int CMP_DIS_BIT   = 8;
  localparam int MSENSE_BIT    = 9;
  localparam int UHYST_BIT     = 10;
  localparam int FSW_BIT       = 11;
  localparam int SSW_BIT       = 12;
  localparam int OFFS_LSB      = 0;
  localparam int GAIN_LSB      = 8;

  // Which bits a trim write keeps, per address
  function automatic logic [15:0] trim_mask(input logic [3:0] addr);
    if (addr == ADDR_DCL_CTRL) begin
      return DCL_TRIM_MASK;
    end
    return (addr == ADDR_FORCE) ? FORCE_TRIM_MASK : TRIM_MASK;
  endfunction : trim_mask

  function automatic logic [15:0] trim_reset(input logic [3:0] addr);
    if (addr == ADDR_DCL_CTRL) begin
      return DCL_TRIM_RST;
    end
    return (addr == ADDR_FORCE) ? FORCE_TRIM_RST : TRIM_RST;
  endfunction : trim_reset

endpackage : pin_pkg

// ### design/pin_input_sync.sv
`timescale 1ns/1ps
module pin_input_sync #(
  parameter int W = 4
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  // ----------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  // ----------------------------------------------------------------
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
          s1_r[i]      <= 1'b1;
          s2_r[i]      <= 1'b1;
          s3_r[i]      <= 1'b1;
          level_out[i] <= 1'b1;
        end else begin
          s1_r[i] <= pin_in[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            level_out[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

endmodule : pin_input_sync

// ### design/pin_shift_in.sv
`timescale 1ns/1ps
module pin_shift_in
  import pin_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 nrst_in,
  input  wire logic                 shift_en_in,
  input  wire logic                 bit_in,
  output logic      [WORD_BITS-1:0] word_out
);

  // ----------------------------------------------------------------
  // Serial word, first bit ends up on top
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      word_out <= '0;
    end else if (shift_en_in) begin
      word_out <= {word_out[WORD_BITS-2:0], bit_in};
    end
  end

endmodule : pin_shift_in

// ### tb/host_spi_model.sv
`timescale 1ns/1ps
module host_spi_model (
  output logic sel_n_out,
  output logic sclk_out,
  output logic sdi_out,
  output logic update_n_out
);
  // --------------------------------------------
  // Host side of the serial link
  // --------------------------------------------
  // The link clock stands high between frames, so only frame bits give edges
  initial begin
    sel_n_out = 1'b1;
    sclk_out = 1'b1;
    sdi_out = 1'b1;
    update_n_out = 1'b1;
  end

  // Stage high holds the strobe up across the select rise
  task automatic send(input logic [23:0] word, input logic stage);
    update_n_out = stage;
    sel_n_out = 1'b0;
    #32;
    for (int i = 23; i >= 0; i--) begin
      sclk_out = 1'b0;
      sdi_out = word[i];
      #32;
      sclk_out = 1'b1;
      #32;
    end
    sel_n_out = 1'b1;
    // Released data line shows no stale value
    sdi_out = ~sdi_out;
    #32;
  endtask : send

  task automatic apply();
    update_n_out = 1'b0;
  endtask : apply
endmodule : host_spi_model

// ### tb/pin_channel_serial_register_map_tb_top.sv
`timescale 1ns/1ps
module pin_channel_serial_register_map_tb_top;
  logic clk, nrst;
  wire sel_n, sclk, sdi, upd_n;
  logic [1:0][1:0] slew;
  logic [1:0] leak, term, ldis, inv, diff, lcal, hv, force_mode_select, measure_mode_select, fsw, ssw;
  logic [1:0][3:0] res;
  logic [1:0][2:0] comparator_hysteresis_select, droop, range;
  logic [1:0][15:0][15:0] lvl;
  logic [1:0][15:0] chi, upl, clh, sup, vofs, iofs, clo, llo;
  logic [1:0] clen, ffl, mfl, cdis, msel, uhy;
  logic sdo;
  logic [1:0][15:0][7:0] otrim;
  logic [1:0][15:0][6:0] gtrim;
  int num_errors, comparisons;

  host_spi_model i_host (.sel_n_out(sel_n), .sclk_out(sclk), .sdi_out(sdi), .update_n_out(upd_n));

  pin_serial_regs i_dut (.CLK_SYS_IN(clk), .NRST_IN(nrst), .SEL_N_IN(sel_n), .SCLK_IN(sclk),
    .SDI_IN(sdi), .UPDATE_N_IN(upd_n), .SDO_OUT(sdo), .SLEW_CONTROL_OUT(slew),
    .LOW_LEAK_SELECT_OUT(leak), .TERMINATION_SELECT_OUT(term), .ACTIVE_LOAD_DISABLE_OUT(ldis),
    .DATA_INVERT_OUT(inv), .DIFFERENTIAL_SELECT_OUT(diff), .LOAD_CALIBRATION_ENABLE_OUT(lcal),
    .HIGH_VOLTAGE_DRIVE_ENABLE_OUT(hv), .OUTPUT_RESISTANCE_SELECT_OUT(res),
    .COMPARATOR_HYSTERESIS_SELECT_OUT(comparator_hysteresis_select), .CABLE_DROOP_COMP_OUT(droop),
    .FORCE_MODE_SELECT_OUT(force_mode_select), .MEASURE_MODE_SELECT_OUT(measure_mode_select),
    .CURRENT_RANGE_SELECT_OUT(range), .CLAMP_ENABLE_OUT(clen), .FORCE_OUTPUT_FLOAT_OUT(ffl),
    .MEASURE_OUTPUT_FLOAT_OUT(mfl), .UNIT_COMPARATOR_DISABLE_OUT(cdis),
    .MEASURE_INPUT_SELECT_OUT(msel),
    .UNIT_COMPARATOR_HYSTERESIS_ON_OUT(uhy), .FORCE_SWITCH_ENABLE_OUT(fsw),
    .SENSE_SWITCH_ENABLE_OUT(ssw), .LEVEL_CODE_OUT(lvl), .COMPARE_HIGH_LEVEL_OUT(chi),
    .UNIT_UPPER_LIMIT_OUT(upl), .COMPARE_LOW_LEVEL_OUT(clo), .UNIT_LOWER_LIMIT_OUT(llo),
    .UNIT_CLAMP_HIGH_OUT(clh), .SUPER_VOLTAGE_LEVEL_OUT(sup), .VOLTAGE_OFFSET_LEVEL_OUT(vofs),
    .CURRENT_OFFSET_LEVEL_OUT(iofs), .OFFSET_TRIM_OUT(otrim), .GAIN_TRIM_OUT(gtrim));

  // --------------------------------------------
  // Shared tasks
  // --------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Outputs settle about five clocks after the select rise; ten leaves margin
  task automatic wr(input logic [23:0] w, input logic stage);
    @(posedge clk);
    #1;
    i_host.send(w, stage);
    repeat (10) @(posedge clk);
    #1;
  endtask : wr

  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // --------------------------------------------
  // Scenarios
  // --------------------------------------------
  task automatic t_reset();
    chk({leak[0], slew[0]}, 16'h0004);
    chk(res[1], 16'h0008);
    chk({measure_mode_select[0], force_mode_select[0]}, 16'h0003);
    chk(gtrim[0][9], 16'h0040);
    chk(otrim[1][1], 16'h0080);
  endtask : t_reset

  task automatic t_ctrl();
    wr(24'ha001ff, 1'b0);
    chk({hv[1], lcal[1], diff[1], inv[1], ldis[1], term[1], leak[1], slew[1]}, 16'h01ff);
    chk({hv[0], lcal[0], diff[0], inv[0], ldis[0], term[0], leak[0], slew[0]}, 16'h0004);
    chk(16'(sdo), 16'h0001);
  endtask : t_ctrl

  task automatic t_level();
    wr(24'h34fffe, 1'b0);
    chk(chi[0], 16'hfffe);
    chk(upl[1], 16'hfffe);
    chk(lvl[1][4], 16'hfffe);
    wr(24'h1e0001, 1'b0);
    chk(clh[0], 16'h0001);
    chk(sup[0], 16'h0001);
    chk(sup[1], 16'h4000);
    wr(24'h350123, 1'b0);
    chk(clo[0], 16'h0123);
    chk(llo[1], 16'h0123);
  endtask : t_level

  task automatic t_offs();
    wr(24'h1d1234, 1'b0);
    wr(24'h2dabcd, 1'b0);
    chk(vofs[0], 16'h1234);
    chk(vofs[1], 16'h1234);
    chk(iofs[0], 16'habcd);
    chk(iofs[1], 16'habcd);
  endtask : t_offs

  task automatic t_unit();
    wr(24'h181ffc, 1'b0);
    chk({ssw[0], fsw[0], range[0], measure_mode_select[0], force_mode_select[0]}, 16'h007c);
    chk({ssw[1], fsw[1], range[1], measure_mode_select[1], force_mode_select[1]}, 16'h0003);
    chk({uhy[0], msel[0], cdis[0], mfl[0], ffl[0], clen[0]}, 16'h003f);
    chk({uhy[1], msel[1], cdis[1], mfl[1], ffl[1], clen[1]}, 16'h0000);
    wr(24'h58ffff, 1'b0);
    chk(otrim[0][8], 16'h0080);
  endtask : t_unit

  task automatic t_cal();
    wr(24'h59ffff, 1'b1);
    chk({gtrim[0][9], otrim[0][9]}, 16'h7fff);
    chk(lvl[0][9], 16'h4000);
    wr(24'h61ffff, 1'b1);
    chk({gtrim[1][1], otrim[1][1]}, 16'h3fff);
    wr(24'h5003ff, 1'b1);
    chk({droop[0], comparator_hysteresis_select[0], res[0]}, 16'h03ff);
    chk(slew[0], 16'h0000);
  endtask : t_cal

  task automatic t_stage();
    wr(24'h125a5a, 1'b1);
    chk(lvl[0][2], 16'h4000);
    i_host.apply();
    repeat (10) @(posedge clk);
    #1;
    chk(lvl[0][2], 16'h5a5a);
    chk(lvl[1][2], 16'h4000);
  endtask : t_stage

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    num_errors = 0;
    comparisons = 0;
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    t_reset();
    t_ctrl();
    t_level();
    t_offs();
    t_unit();
    t_cal();
    t_stage();
    stop_test();
  end
endmodule : pin_channel_serial_register_map_tb_top
